// [rtl/ecl_defines.svh]
`ifndef ECL_DEFINES_SVH
`define ECL_DEFINES_SVH

`define ECL_EE_DEPTH 2048
`define ECL_EE_AW 11
`define ECL_SP_AW 8
`define ECL_RA_W 13
`define ECL_RA_HI_W 5
`define ECL_COND_W 4
`define ECL_TAG_N 16

`define ECL_OP_NULL 8'hb0
`define ECL_COND_NIB 4'hb
`define ECL_OP_PAUSE 8'hfe
`define ECL_OP_END 8'hff
`define ECL_OP_IOUPD 8'h80
`define ECL_OP_CAL 8'h0a
`define ECL_DATA_MAX 8'h7f
`define ECL_COND_NONE 4'h0
`define ECL_PIN_NONE 2'h0
`define ECL_STARTUP_CYC 2'h3

`endif

// [rtl/ecl_pkg.sv]
`include "ecl_defines.svh"

package ecl_pkg;

    typedef enum logic [3:0] {
        ECL_ST_STARTUP,
        ECL_ST_IDLE,
        ECL_ST_SAVE_OP,
        ECL_ST_SAVE_A1,
        ECL_ST_SAVE_A2,
        ECL_ST_SAVE_DATA,
        ECL_ST_SAVE_SUM,
        ECL_ST_LOAD_OP,
        ECL_ST_LOAD_A1,
        ECL_ST_LOAD_A2,
        ECL_ST_LOAD_DATA,
        ECL_ST_LOAD_SUM
    } ecl_state_e;

    typedef struct packed {
        logic en;
        logic [`ECL_RA_W-1:0] addr;
        logic [7:0] data;
    } ecl_regwr_s;

    typedef struct packed {
        logic busy;
        logic fault;
        logic complete;
    } ecl_status_s;

endpackage : ecl_pkg

// [rtl/ecl_loader.sv]
`timescale 1ns/100ps
`include "ecl_defines.svh"

module ecl_loader import ecl_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Configuration-select pins
    input wire logic condition_select_pin_hi,
    input wire logic condition_select_pin_lo,
    // Control
    input wire logic soft_reset,
    input wire logic save_enable,
    input wire logic save_cmd,
    input wire logic load_cmd,
    input wire logic [`ECL_COND_W-1:0] sw_condition,
    // Scratchpad read port
    output logic [`ECL_SP_AW-1:0] scratch_addr,
    input wire logic [7:0] scratch_data,
    // Register map
    output logic [`ECL_RA_W-1:0] regmap_rd_addr,
    input wire logic [7:0] regmap_rd_data,
    output ecl_regwr_s regmap_wr,
    output logic io_update,
    output logic calibrate_start,
    // Status
    output ecl_status_s status,
    output logic [`ECL_COND_W-1:0] active_condition,
    output logic [`ECL_TAG_N-1:0] tag_board
);

    logic [1:0] pin_meta_r;
    logic [1:0] pin_sync_r;
    logic [1:0] pin_condition_capture_r;
    logic [1:0] start_cnt_r;
    ecl_state_e state_r;
    logic [`ECL_EE_AW-1:0] ee_ptr_r;
    logic [`ECL_SP_AW-1:0] sp_ptr_r;
    logic [`ECL_RA_W-1:0] addr_r;
    logic [7:0] cnt_r;
    logic [7:0] sum_r;
    logic exec_r;
    logic [`ECL_TAG_N-1:0] tags_r;
    logic fault_r;
    logic complete_r;
    logic io_update_r;
    logic calibrate_r;
    ecl_regwr_s regwr_r;
    logic [`ECL_COND_W-1:0] cond_r;
    logic [7:0] ee_mem [0:`ECL_EE_DEPTH-1];
    logic [`ECL_COND_W-1:0] cond;
    logic [7:0] ee_byte;
    logic [7:0] op;
    logic [7:0] save_byte;
    logic is_data;
    logic is_cond;
    logic is_end;
    logic tags_any;
    logic exec_ok;
    logic ee_we;
    logic startup_done;
    logic start_load;
    logic start_save;
    logic in_save;
    logic in_load;
    // Active condition selection.
    always_comb begin
        if (sw_condition != `ECL_COND_NONE) begin
            cond = sw_condition;
        end else begin
            cond = {2'b00, pin_condition_capture_r};
        end
    end

    // Instruction decode shared by save and download.
    assign ee_byte = ee_mem[ee_ptr_r];
    assign in_load = state_r inside {ECL_ST_LOAD_OP, ECL_ST_LOAD_A1,
                     ECL_ST_LOAD_A2, ECL_ST_LOAD_DATA, ECL_ST_LOAD_SUM};
    assign in_save = state_r inside {ECL_ST_SAVE_OP, ECL_ST_SAVE_A1,
                     ECL_ST_SAVE_A2, ECL_ST_SAVE_DATA, ECL_ST_SAVE_SUM};
    assign op = in_load ? ee_byte : scratch_data;
    assign is_data = (op <= `ECL_DATA_MAX) && (op != `ECL_OP_CAL);
    assign is_cond = (op[7:4] == `ECL_COND_NIB);
    assign is_end = (op == `ECL_OP_END);
    assign tags_any = |tags_r;

    // Execute decision for ordinary instructions.
    always_comb begin
        if (cond == `ECL_COND_NONE) begin
            exec_ok = 1'b1;
        end else if (!tags_any) begin
            exec_ok = 1'b1;
        end else begin
            exec_ok = tags_r[cond];
        end
    end

    // Byte written into the store during a save.
    always_comb begin
        if (state_r == ECL_ST_SAVE_DATA) begin
            save_byte = regmap_rd_data;
        end else if (state_r == ECL_ST_SAVE_SUM) begin
            save_byte = sum_r;
        end else begin
            save_byte = scratch_data;
        end
    end

    assign ee_we = in_save &&
                   !((state_r == ECL_ST_SAVE_OP) &&
                     (op == `ECL_OP_PAUSE));
    assign startup_done = (state_r == ECL_ST_STARTUP) &&
                          (start_cnt_r == `ECL_STARTUP_CYC);
    assign start_load = (state_r == ECL_ST_IDLE) && load_cmd;
    assign start_save = (state_r == ECL_ST_IDLE) && !load_cmd &&
                        save_cmd && save_enable;

    // Select pin synchroniser.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_meta_r <= `ECL_PIN_NONE;
            pin_sync_r <= `ECL_PIN_NONE;
        end else begin
            pin_meta_r <= {condition_select_pin_hi, condition_select_pin_lo};
            pin_sync_r <= pin_meta_r;
        end
    end

    // Startup delay and pin condition capture.
    always_ff @(posedge core_clk) begin
        if (reset || soft_reset) begin
            start_cnt_r <= `ECL_PIN_NONE;
        end else if ((state_r == ECL_ST_STARTUP) && !startup_done) begin
            start_cnt_r <= start_cnt_r + 2'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_condition_capture_r <= `ECL_PIN_NONE;
        end else if (startup_done) begin
            pin_condition_capture_r <= pin_sync_r;
        end
    end

    // Sequencer.
    always_ff @(posedge core_clk) begin
        if (reset || soft_reset) begin
            state_r <= ECL_ST_STARTUP;
        end else begin
            unique case (state_r)
                ECL_ST_STARTUP: begin
                    if (startup_done && (pin_sync_r != `ECL_PIN_NONE)) begin
                        state_r <= ECL_ST_LOAD_OP;
                    end else if (startup_done) begin
                        state_r <= ECL_ST_IDLE;
                    end
                end
                ECL_ST_IDLE: begin
                    if (start_load) begin
                        state_r <= ECL_ST_LOAD_OP;
                    end else if (start_save) begin
                        state_r <= ECL_ST_SAVE_OP;
                    end
                end
                ECL_ST_SAVE_OP: begin
                    if (is_end || (op == `ECL_OP_PAUSE)) begin
                        state_r <= ECL_ST_IDLE;
                    end else if (is_data) begin
                        state_r <= ECL_ST_SAVE_A1;
                    end
                end
                ECL_ST_SAVE_A1: state_r <= ECL_ST_SAVE_A2;
                ECL_ST_SAVE_A2: state_r <= ECL_ST_SAVE_DATA;
                ECL_ST_SAVE_DATA: begin
                    if (cnt_r == 8'h00) begin
                        state_r <= ECL_ST_SAVE_SUM;
                    end
                end
                ECL_ST_SAVE_SUM: state_r <= ECL_ST_SAVE_OP;
                ECL_ST_LOAD_OP: begin
                    if (is_end) begin
                        state_r <= ECL_ST_IDLE;
                    end else if (is_data) begin
                        state_r <= ECL_ST_LOAD_A1;
                    end
                end
                ECL_ST_LOAD_A1: state_r <= ECL_ST_LOAD_A2;
                ECL_ST_LOAD_A2: state_r <= ECL_ST_LOAD_DATA;
                ECL_ST_LOAD_DATA: begin
                    if (cnt_r == 8'h00) begin
                        state_r <= ECL_ST_LOAD_SUM;
                    end
                end
                ECL_ST_LOAD_SUM: state_r <= ECL_ST_LOAD_OP;
                default: state_r <= ECL_ST_IDLE;
            endcase
        end
    end
    // Store pointer.
    always_ff @(posedge core_clk) begin
        if (reset || soft_reset || startup_done || start_load) begin
            ee_ptr_r <= '0;
        end else if ((state_r == ECL_ST_SAVE_OP) && is_end) begin
            ee_ptr_r <= '0;
        end else if ((state_r == ECL_ST_LOAD_OP) && is_end) begin
            ee_ptr_r <= '0;
        end else if (ee_we || in_load) begin
            ee_ptr_r <= ee_ptr_r + 1'b1;
        end
    end

    // Scratchpad pointer.
    always_ff @(posedge core_clk) begin
        if (reset || soft_reset || start_save) begin
            sp_ptr_r <= '0;
        end else if ((state_r == ECL_ST_SAVE_OP) &&
                     (is_end || (op == `ECL_OP_PAUSE))) begin
            sp_ptr_r <= '0;
        end else if (state_r inside {ECL_ST_SAVE_OP, ECL_ST_SAVE_A1,
                                     ECL_ST_SAVE_A2}) begin
            sp_ptr_r <= sp_ptr_r + 1'b1;
        end
    end

    // Store array.
    always_ff @(posedge core_clk) begin
        if (ee_we) begin
            ee_mem[ee_ptr_r] <= save_byte;
        end
    end

    // Target address, byte count and checksum.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_r <= '0;
            cnt_r <= 8'h00;
            sum_r <= 8'h00;
        end else begin
            unique case (state_r)
                ECL_ST_SAVE_OP, ECL_ST_LOAD_OP: begin
                    cnt_r <= op;
                end
                ECL_ST_SAVE_A1, ECL_ST_LOAD_A1: begin
                    addr_r[`ECL_RA_W-1:8] <= op[`ECL_RA_HI_W-1:0];
                end
                ECL_ST_SAVE_A2, ECL_ST_LOAD_A2: begin
                    addr_r[7:0] <= op;
                    sum_r <= 8'h00;
                end
                ECL_ST_SAVE_DATA: begin
                    addr_r <= addr_r + 1'b1;
                    cnt_r <= cnt_r - 8'h01;
                    sum_r <= sum_r + regmap_rd_data;
                end
                ECL_ST_LOAD_DATA: begin
                    addr_r <= addr_r + 1'b1;
                    cnt_r <= cnt_r - 8'h01;
                    sum_r <= sum_r + ee_byte;
                end
                default: ;
            endcase
        end
    end

    // Execute decision held across a data entry.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            exec_r <= 1'b0;
        end else if (state_r == ECL_ST_LOAD_OP) begin
            exec_r <= exec_ok;
        end
    end
    // Condition tag board.
    always_ff @(posedge core_clk) begin
        if (reset || startup_done || start_load) begin
            tags_r <= '0;
        end else if ((state_r == ECL_ST_LOAD_OP) && is_cond) begin
            if (op == `ECL_OP_NULL) begin
                tags_r <= '0;
            end else begin
                tags_r[op[3:0]] <= 1'b1;
            end
        end
    end

    // Download status flags.
    always_ff @(posedge core_clk) begin
        if (reset || startup_done || start_load) begin
            fault_r <= 1'b0;
            complete_r <= 1'b0;
        end else if ((state_r == ECL_ST_LOAD_SUM) && exec_r &&
                     (ee_byte != sum_r)) begin
            fault_r <= 1'b1;
        end else if ((state_r == ECL_ST_LOAD_OP) && is_end) begin
            complete_r <= !fault_r;
        end
    end

    // Action pulses and register writes.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            io_update_r <= 1'b0;
            calibrate_r <= 1'b0;
        end else begin
            io_update_r <= (state_r == ECL_ST_LOAD_OP) &&
                           (op == `ECL_OP_IOUPD) && exec_ok;
            calibrate_r <= (state_r == ECL_ST_LOAD_OP) &&
                           (op == `ECL_OP_CAL) && exec_ok;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            regwr_r <= '0;
        end else begin
            regwr_r.en <= (state_r == ECL_ST_LOAD_DATA) && exec_r;
            regwr_r.addr <= addr_r;
            regwr_r.data <= ee_byte;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cond_r <= `ECL_COND_NONE;
        end else begin
            cond_r <= cond;
        end
    end

    assign scratch_addr = sp_ptr_r;
    assign regmap_rd_addr = addr_r;
    assign regmap_wr = regwr_r;
    assign io_update = io_update_r;
    assign calibrate_start = calibrate_r;
    assign status.busy = (state_r != ECL_ST_IDLE);
    assign status.fault = fault_r;
    assign status.complete = complete_r;
    assign active_condition = cond_r;
    assign tag_board = tags_r;
endmodule : ecl_loader

// [tb/ecl_loader_monitor.sv]
`timescale 1ns/100ps
`include "ecl_defines.svh"

module ecl_loader_monitor import ecl_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic soft_reset,
    // Control
    input wire logic load_cmd,
    input wire logic [`ECL_COND_W-1:0] sw_condition,
    // Observed outputs
    input wire ecl_regwr_s regmap_wr,
    input wire logic io_update,
    input wire logic calibrate_start,
    input wire ecl_status_s status,
    input wire logic [`ECL_COND_W-1:0] active_condition,
    input wire logic [`ECL_TAG_N-1:0] tag_board
);
    logic exec_ok;
    assign exec_ok = (active_condition == 4'h0) ||
        (tag_board == 16'h0000) ||
        tag_board[active_condition];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset || soft_reset);

    sequence s_take;
        !status.busy && load_cmd;
    endsequence

    sequence s_start;
        status.busy;
    endsequence

    a_take_busy: assert property (s_take |=> s_start)
        else $error("Load command not taken.");
    a_wr_exec: assert property (regmap_wr.en |-> $past(exec_ok))
        else $error("Register write while skipping.");
    a_io_exec: assert property (io_update |-> $past(exec_ok))
        else $error("Update pulse while skipping.");
    a_cal_exec: assert property (calibrate_start |-> $past(exec_ok))
        else $error("Calibrate pulse while skipping.");
    a_tag_zero: assert property (tag_board[0] == 1'b0)
        else $error("Tag zero set.");
    a_sw_wins: assert property (!$past(reset) && !$past(soft_reset) &&
        $past(sw_condition) != 4'h0 |-> active_condition == $past(sw_condition))
        else $error("Software condition not used.");
    a_pin_range: assert property (!$past(reset) && !$past(soft_reset) &&
        $past(sw_condition) == 4'h0 |-> active_condition <= 4'h3)
        else $error("Pin condition out of range.");
    a_tags_grow: assert property (status.busy && $past(status.busy) &&
        tag_board != 16'h0000 |->
        (tag_board & $past(tag_board)) == $past(tag_board))
        else $error("Tag lost without null condition.");
    a_flags_excl: assert property (!(status.fault && status.complete))
        else $error("Fault and complete both set.");
    a_done_idle: assert property ($rose(status.complete) |-> !status.busy)
        else $error("Complete without idle.");
endmodule : ecl_loader_monitor

bind ecl_loader ecl_loader_monitor u_ecl_loader_monitor (
    .core_clk(core_clk),
    .reset(reset),
    .soft_reset(soft_reset),
    .load_cmd(load_cmd),
    .sw_condition(sw_condition),
    .regmap_wr(regmap_wr),
    .io_update(io_update),
    .calibrate_start(calibrate_start),
    .status(status),
    .active_condition(active_condition),
    .tag_board(tag_board)
);

// [tb/ecl_far_model.sv]
`timescale 1ns/100ps
`include "ecl_defines.svh"

module ecl_far_model (
    // Setup select
    input wire logic page,
    // Scratchpad
    input wire logic [`ECL_SP_AW-1:0] scratch_addr,
    output logic [7:0] scratch_data,
    // Register map
    input wire logic [`ECL_RA_W-1:0] regmap_rd_addr,
    output logic [7:0] regmap_rd_data
);
    // First setup: data entries, condition and action bytes, a pause.
    localparam logic [87:0] PROG_A = 88'h000010b1000020b2800afe;
    // Second setup: null, a fresh condition, an update, the end byte.
    localparam logic [31:0] PROG_B = 32'hb0b380ff;

    always_comb begin
        if (page) begin
            scratch_data = `ECL_OP_END;
            if (scratch_addr < 8'h04) begin
                scratch_data = PROG_B[(3 - int'(scratch_addr)) * 8 +: 8];
            end
        end else begin
            scratch_data = `ECL_OP_PAUSE;
            if (scratch_addr < 8'h0b) begin
                scratch_data = PROG_A[(10 - int'(scratch_addr)) * 8 +: 8];
            end
        end
    end
    assign regmap_rd_data = regmap_rd_addr[7:0] ^ 8'h5a;
endmodule : ecl_far_model

// [tb/ecl_loader_tb.sv]
`timescale 1ns/100ps
`include "ecl_defines.svh"

module ecl_loader_tb import ecl_pkg::*;;
    typedef struct packed {
        logic [3:0] cond;
        logic [3:0] w20;
        logic [3:0] nio;
        logic [3:0] ncal;
    } ecl_row_s;

    logic core_clk, reset, condition_select_pin_hi, condition_select_pin_lo;
    logic soft_reset, save_enable, save_cmd, load_cmd, page;
    logic [3:0] sw_condition, active_condition;
    logic [7:0] scratch_addr, scratch_data, regmap_rd_data;
    logic [12:0] regmap_rd_addr;
    logic [15:0] tag_board, tag_seen;
    logic io_update, calibrate_start;
    ecl_regwr_s regmap_wr;
    ecl_status_s status;
    ecl_row_s rows [5];
    int bad_count, compares, n10, n20, nio, ncal;

    ecl_loader u_ecl_loader (.core_clk(core_clk), .reset(reset),
        .condition_select_pin_hi(condition_select_pin_hi),
        .condition_select_pin_lo(condition_select_pin_lo),
        .soft_reset(soft_reset), .save_enable(save_enable),
        .save_cmd(save_cmd), .load_cmd(load_cmd),
        .sw_condition(sw_condition), .scratch_addr(scratch_addr),
        .scratch_data(scratch_data), .regmap_rd_addr(regmap_rd_addr),
        .regmap_rd_data(regmap_rd_data), .regmap_wr(regmap_wr),
        .io_update(io_update), .calibrate_start(calibrate_start),
        .status(status), .active_condition(active_condition),
        .tag_board(tag_board));

    ecl_far_model u_ecl_far_model (.page(page), .scratch_addr(scratch_addr),
        .scratch_data(scratch_data), .regmap_rd_addr(regmap_rd_addr),
        .regmap_rd_data(regmap_rd_data));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic clr;
        n10 = 0;
        n20 = 0;
        nio = 0;
        ncal = 0;
        tag_seen = 16'h0000;
    endtask : clr

    task automatic go_load(input logic [3:0] c);
        @(posedge core_clk);
        clr();
        sw_condition <= c;
        load_cmd <= 1'b1;
        @(posedge core_clk);
        load_cmd <= 1'b0;
    endtask : go_load

    task automatic go_save(input logic pg);
        @(posedge core_clk);
        page <= pg;
        save_enable <= 1'b1;
        @(posedge core_clk);
        save_cmd <= 1'b1;
        @(posedge core_clk);
        save_cmd <= 1'b0;
        wait_idle();
    endtask : go_save

    task automatic wait_idle;
        int i;
        i = 0;
        @(posedge core_clk);
        #1;
        while (status.busy !== 1'b0 && i < 500) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chk(16'(status.busy), 16'h0000);
    endtask : wait_idle

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        tag_seen = tag_seen | tag_board;
        if (io_update === 1'b1) nio++;
        if (calibrate_start === 1'b1) ncal++;
        if (regmap_wr.en === 1'b1) begin
            if (regmap_wr.addr == 13'h0010) n10++;
            if (regmap_wr.addr == 13'h0020) n20++;
            chk(16'(regmap_wr.data), 16'(regmap_wr.addr[7:0] ^ 8'h5a));
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        {reset, soft_reset, save_enable, save_cmd, load_cmd} = 5'h10;
        {condition_select_pin_hi, condition_select_pin_lo} = 2'h0;
        sw_condition = 4'h0;
        page = 1'b0;
        bad_count = 0;
        compares = 0;
        clr();
        rows = '{'{4'h0, 4'h1, 4'h2, 4'h1}, '{4'h1, 4'h1, 4'h1, 4'h1},
            '{4'h2, 4'h0, 4'h1, 4'h1}, '{4'h3, 4'h0, 4'h1, 4'h0},
            '{4'hf, 4'h0, 4'h0, 4'h0}};
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        chk(16'(status.busy), 16'h0000);
        chk(16'(status.complete), 16'h0000);
        @(posedge core_clk);
        save_cmd <= 1'b1;
        @(posedge core_clk);
        save_cmd <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(16'(status.busy), 16'h0000);
        go_save(1'b0);
        go_save(1'b1);
        foreach (rows[i]) begin
            go_load(rows[i].cond);
            wait_idle();
            chk(16'(n10), 16'h0001);
            chk(16'(n20), 16'(rows[i].w20));
            chk(16'(nio), 16'(rows[i].nio));
            chk(16'(ncal), 16'(rows[i].ncal));
            chk(tag_seen, 16'h000e);
            chk(tag_board, 16'h0008);
            chk(16'(status.complete), 16'h0001);
            chk(16'(status.fault), 16'h0000);
        end
        @(posedge core_clk);
        condition_select_pin_lo <= 1'b1;
        sw_condition <= 4'h0;
        repeat (4) @(posedge core_clk);
        clr();
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        wait_idle();
        chk(16'(n20), 16'h0001);
        chk(16'(nio), 16'h0001);
        chk(16'(active_condition), 16'h0001);
        chk(16'(status.complete), 16'h0001);
        go_load(4'h2);
        wait_idle();
        chk(16'(n20), 16'h0000);
        chk(16'(active_condition), 16'h0002);
        print_verdict();
    end
endmodule : ecl_loader_tb
